// >>> fls_defs.vh
// constants for the feeder-to-lathe status output block
`ifndef FLS_DEFS_VH
`define FLS_DEFS_VH
`define FLS_SPARE_OFF       2'h0
`define FLS_SPARE_ERROR     2'h1
`define FLS_SPARE_SHORT     2'h2
`define FLS_SPARE_RUN       2'h3
`define FLS_EOB_AFTER_CLAMP 2'h0
`define FLS_EOB_IMMEDIATE   2'h1
`define FLS_EOB_AT_REQUEST  2'h2
`define FLS_ACK_HOLD        1'h0
`define FLS_ACK_PULSE       1'h1
`define FLS_ACK_PULSE_NS    100000
`define FLS_CLK_NS          50
`define FLS_ACK_PULSE_CYC   ((`FLS_ACK_PULSE_NS + `FLS_CLK_NS - 1) / `FLS_CLK_NS)
`endif

// >>> fls_handshake.v
// request/acknowledge handshake for the action-complete output
`timescale 1ns/10ps
`include "fls_defs.vh"
module fls_handshake #(
	parameter PULSE_CYC = `FLS_ACK_PULSE_CYC
) (
	input  wire clk_sys,
	input  wire srst,
	input  wire action_request,
	input  wire action_finished,
	input  wire ack_mode,
	output reg  action_done,
	output reg  busy
);
	localparam ST_IDLE = 3'h1;
	localparam ST_WORK = 3'h2;
	localparam ST_ACK  = 3'h4;
	reg [2:0]  state;
	reg [15:0] count;
	always @(posedge clk_sys) begin
		if (srst) begin
			state <= ST_IDLE;
			action_done <= 1'b0;
			busy <= 1'b0;
			count <= 16'h0000;
		end else begin
			case (state)
				ST_IDLE: begin
					action_done <= 1'b0;
					if (action_request) begin
						state <= ST_WORK;
						busy <= 1'b1;
					end
				end
				ST_WORK: begin
					if (action_finished) begin
						state <= ST_ACK;
						busy <= 1'b0;
						action_done <= 1'b1;
						count <= 16'h0000;
					end
				end
				ST_ACK: begin
					if (ack_mode == `FLS_ACK_PULSE) begin
						if (count < PULSE_CYC[15:0] - 16'h0001)
							count <= count + 16'h0001;
						else
							action_done <= 1'b0;
					end
					if (!action_request) begin
						state <= ST_IDLE;
						action_done <= 1'b0;
					end
				end
				default: begin
					state <= ST_IDLE;
					action_done <= 1'b0;
					busy <= 1'b0;
				end
			endcase
		end
	end
endmodule

// >>> fls_status_outputs.v
// feeder-to-lathe status and handshake outputs
// Function
// - fault-free output is on while the feeder has no error and off to report an error.
// - outside the automatic cycle fault-free needs the safety chain closed and the pusher at rear.
// - the spare output follows a function picked by a configuration input.
// - end-of-bar is on when the bar is short and off while enough material remains.
// - by default end-of-bar rises after the feed/clamp step and falls at the next clamp open.
// - the end-of-bar timing method is picked by a configuration input.
// - spindle permit is on when rotation is allowed and off e.g. with the pusher in the spindle.
// - action-complete rises when the requested action is done and is off while idle.
// - the way action-complete is formed is picked by a configuration input.
// - the clamp-open input polarity can be inverted by a configuration input.
`timescale 1ns/10ps
`include "fls_defs.vh"
module fls_status_outputs #(
	parameter PULSE_CYC = `FLS_ACK_PULSE_CYC
) (
	input  wire       clk_sys,
	input  wire       srst,
	input  wire       auto_cycle,
	input  wire       fault,
	input  wire       safety_chain_relay,
	input  wire       pusher_at_rear,
	input  wire       pusher_in_spindle,
	input  wire       short_bar_detect,
	input  wire       feed_clamp_done,
	input  wire       clamp_open_in,
	input  wire       clamp_invert,
	input  wire       action_request,
	input  wire       action_finished,
	input  wire [1:0] spare_mode,
	input  wire [1:0] eob_mode,
	input  wire       ack_mode,
	output reg        fault_free_relay,
	output reg        spare_output_relay,
	output reg        short_bar_relay,
	output reg        spindle_permit_relay,
	output wire       action_done_relay,
	output reg        action_busy
);
	wire clamp_open;
	wire hs_busy;
	reg  clamp_open_d;
	reg  short_pending;
	reg  next_short_bar;
	reg  next_spare;
	reg  next_fault_free;
	wire clamp_open_edge;
	assign clamp_open = clamp_open_in ^ clamp_invert;
	assign clamp_open_edge = clamp_open & ~clamp_open_d;
	always @* begin
		if (auto_cycle)
			next_fault_free = ~fault;
		else
			next_fault_free = ~fault & safety_chain_relay & pusher_at_rear;
	end
	always @* begin
		case (spare_mode)
			`FLS_SPARE_ERROR: next_spare = ~next_fault_free;
			`FLS_SPARE_SHORT: next_spare = short_pending;
			`FLS_SPARE_RUN:   next_spare = auto_cycle;
			default:          next_spare = 1'b0;
		endcase
	end
	always @* begin
		next_short_bar = short_bar_relay;
		case (eob_mode)
			`FLS_EOB_IMMEDIATE: next_short_bar = short_bar_detect;
			`FLS_EOB_AT_REQUEST: begin
				if (short_pending && action_request)
					next_short_bar = 1'b1;
				else if (clamp_open_edge)
					next_short_bar = 1'b0;
			end
			default: begin
				if (short_pending && feed_clamp_done)
					next_short_bar = 1'b1;
				else if (clamp_open_edge)
					next_short_bar = 1'b0;
			end
		endcase
	end
	always @(posedge clk_sys) begin
		if (srst) begin
			clamp_open_d <= clamp_open; // no false edge after reset
			short_pending <= 1'b0;
			fault_free_relay <= 1'b0;
			spare_output_relay <= 1'b0;
			short_bar_relay <= 1'b0;
			spindle_permit_relay <= 1'b0;
			action_busy <= 1'b0;
		end else begin
			clamp_open_d <= clamp_open;
			if (short_bar_detect)
				short_pending <= 1'b1;
			else if (next_short_bar && !short_bar_relay)
				short_pending <= 1'b0;
			fault_free_relay <= next_fault_free;
			spare_output_relay <= next_spare;
			short_bar_relay <= next_short_bar;
			spindle_permit_relay <= ~pusher_in_spindle & ~fault;
			action_busy <= hs_busy;
		end
	end
	// lathe is trusted to hold the request until acknowledged
	fls_handshake #(
		.PULSE_CYC(PULSE_CYC)
	) u_hs (
		.clk_sys        (clk_sys),
		.srst           (srst),
		.action_request (action_request),
		.action_finished(action_finished),
		.ack_mode       (ack_mode),
		.action_done    (action_done_relay),
		.busy           (hs_busy)
	);
endmodule

// >>> fls_status_outputs_sva.sv
// assertions on the status output block ports
`timescale 1ns/10ps
module fls_status_sva (
	input wire logic       clk_sys, srst, auto_cycle, fault, safety_chain_relay,
	input wire logic       pusher_at_rear, pusher_in_spindle, action_request, action_finished,
	input wire logic [1:0] spare_mode,
	input wire logic       fault_free_relay, spare_output_relay, spindle_permit_relay,
	input wire logic       action_done_relay
);
	logic [1:0] up;
	always @(posedge clk_sys) up <= srst ? 2'h0 : {up[0], 1'h1};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	permit_gate_a: assert property (up[1] |-> spindle_permit_relay ==
		!($past(pusher_in_spindle) || $past(fault))) else $error("permit wrong");
	fault_drop_a: assert property (up[1] && $past(fault) |-> !fault_free_relay)
		else $error("fault-free on with fault");
	auto_ok_a: assert property (up[1] && $past(auto_cycle) && !$past(fault) |-> fault_free_relay)
		else $error("fault-free off without fault");
	manual_gate_a: assert property (up[1] && !$past(auto_cycle) &&
		!($past(safety_chain_relay) && $past(pusher_at_rear)) |-> !fault_free_relay)
		else $error("fault-free on outside cycle");
	spare_quiet_a: assert property ($past(spare_mode) == 2'h0 |-> !spare_output_relay)
		else $error("spare on");
	spare_err_a: assert property (up[1] && $past(spare_mode) == 2'h1 |->
		spare_output_relay == !fault_free_relay) else $error("spare not error");
	done_idle_a: assert property (up[1] && !$past(action_request) |-> !action_done_relay)
		else $error("done without request");
	done_cause_a: assert property ($rose(action_done_relay) |-> $past(action_finished))
		else $error("done without finish");
endmodule
bind fls_status_outputs fls_status_sva u_sva (.*);

// >>> fls_lathe_model.sv
// lathe side model issuing action requests
`timescale 1ns/10ps
module fls_lathe_model (
	input  wire logic clk_sys,
	input  wire logic srst,
	input  wire logic go,
	input  wire logic action_done_relay,
	input  wire logic spindle_permit_relay,
	output logic      action_request,
	output logic      spin
);
	always @(posedge clk_sys) begin
		if (srst || action_done_relay) action_request <= 1'h0;
		else if (go) action_request <= 1'h1;
		spin <= spindle_permit_relay;
	end
endmodule

// >>> tb_top.sv
// self-checking bench for the status output block
`timescale 1ns/10ps
module tb_top;
	logic       clk_sys = 0, srst = 1, auto_cycle = 1, fault = 0, go = 0, ack_mode = 0;
	logic       safety_chain_relay = 1, pusher_at_rear = 1, pusher_in_spindle = 0;
	logic       short_bar_detect = 0, feed_clamp_done = 0, clamp_open_in = 0;
	logic       clamp_invert = 0, action_finished = 0;
	logic [1:0] spare_mode = 0, eob_mode = 0;
	wire        fault_free_relay, spare_output_relay, short_bar_relay, spindle_permit_relay;
	wire        action_done_relay, action_busy, action_request, spin;
	int         err_total = 0, num_checks = 0;
	always #25 clk_sys = ~clk_sys;
	fls_status_outputs #(.PULSE_CYC(4)) DUT (.*);
	fls_lathe_model LATHE (.*);
	task cy(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task chk(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: output mismatch", $time);
		end
	endtask
	task t_status;
		@(posedge clk_sys) fault <= 1;
		cy(2);
		chk(fault_free_relay, 0);
		chk(spindle_permit_relay, 0);
		@(posedge clk_sys) {fault, pusher_in_spindle, auto_cycle, pusher_at_rear} <= 4'h2;
		cy(2);
		chk(fault_free_relay, 1);
		@(posedge clk_sys) auto_cycle <= 0;
		cy(2);
		chk(fault_free_relay, 0);
		@(posedge clk_sys) {pusher_in_spindle, pusher_at_rear} <= 2'h3;
		cy(2);
		chk(fault_free_relay, 1);
		chk(spindle_permit_relay, 0);
		@(posedge clk_sys) {pusher_in_spindle, auto_cycle} <= 2'h1;
	endtask
	task t_spare;
		@(posedge clk_sys) fault <= 1;
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_sys) spare_mode <= m[1:0];
			cy(2);
			chk(spare_output_relay, m[0]);
		end
		@(posedge clk_sys) {fault, spare_mode} <= 3'h0;
	endtask
	task t_eob;
		@(posedge clk_sys) short_bar_detect <= 1;
		@(posedge clk_sys) short_bar_detect <= 0;
		cy(2);
		chk(short_bar_relay, 0);
		@(posedge clk_sys) feed_clamp_done <= 1;
		@(posedge clk_sys) feed_clamp_done <= 0;
		cy(2);
		chk(short_bar_relay, 1);
		@(posedge clk_sys) {clamp_open_in, clamp_invert} <= 2'h3;
		@(posedge clk_sys) clamp_open_in <= 0;
		cy(3);
		chk(short_bar_relay, 0);
		@(posedge clk_sys) {eob_mode, short_bar_detect} <= 3'h3;
		cy(2);
		chk(short_bar_relay, 1);
		@(posedge clk_sys) short_bar_detect <= 0;
		cy(2);
		chk(short_bar_relay, 0);
	endtask
	task t_ack(input logic m);
		@(posedge clk_sys) {ack_mode, go} <= {m, 1'h1};
		@(posedge clk_sys) go <= 0;
		cy(3);
		chk(action_done_relay, 0);
		chk(action_busy, 1);
		@(posedge clk_sys) action_finished <= 1;
		@(posedge clk_sys) action_finished <= 0;
		#1 chk(action_done_relay, 1);
		cy(8);
		chk(action_request, 0);
		chk(action_done_relay, 0);
		chk(action_busy, 0);
		chk(spin, 1);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		end_sim;
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		srst <= 0;
		cy(2);
		t_status;
		$display("status test ended");
		t_spare;
		$display("spare test ended");
		t_eob;
		$display("end-of-bar test ended");
		t_ack(0);
		t_ack(1);
		$display("handshake test ended");
		end_sim;
	end
endmodule
